// *** host_terminal.sv ***
// Purpose: Host terminal model on the far side of the serial port
// Assumes: One start bit, 8 data bits LSB first
// Notes: Only data bits are collected; parity and stop are skipped
`timescale 1ns/1ps
module host_terminal #(
    parameter int BIT_CYC = 10416
) (
    input wire logic clk,
    input wire logic rts_n,
    input wire logic txd,
    input wire logic allow,
    output logic cts_n,
    output logic [7:0] rx_byte,
    output int rx_bits
);
    // clear-to-send answers a raised request unless held off
    assign cts_n = ~(allow & ~rts_n);
    // Mid-bit sampling keeps the model blind to edge placement
    initial begin
        rx_byte = 8'h00;
        rx_bits = 0;
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                rx_byte[i] = txd;
                rx_bits++;
            end
            repeat (2 * BIT_CYC) @(posedge clk); // Parity and stop
        end
    end
endmodule // host_terminal

// *** scan_out_pkg.sv ***
// Purpose: Shared constants for the strap configuration and serial output block
// Assumes: 200 MHz system clock
// Notes: Strap codes are {sel_a, sel_b}; config word fields are listed below
package scan_out_pkg;
    // Clock and line rates
    localparam int CLK_HZ = 200_000_000;
    localparam int BAUD_2400 = 2400;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam logic [16:0] DIV_2400 = 17'(CLK_HZ / BAUD_2400);
    localparam logic [16:0] DIV_4800 = 17'(CLK_HZ / BAUD_4800);
    localparam logic [16:0] DIV_9600 = 17'(CLK_HZ / BAUD_9600);
    localparam logic [16:0] DIV_19200 = 17'(CLK_HZ / BAUD_19200);

    // Strap codes {a, b}
    localparam logic [1:0] RATE_9600 = 2'h0;
    localparam logic [1:0] RATE_4800 = 2'h1;
    localparam logic [1:0] RATE_19200 = 2'h2;
    localparam logic [1:0] RATE_2400 = 2'h3;
    localparam logic [1:0] PAR_SPACE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [1:0] TRL_NONE = 2'h0;
    localparam logic [1:0] TRL_CRLF = 2'h1;
    localparam logic [1:0] TRL_TAB = 2'h2;
    localparam logic [1:0] TRL_CR = 2'h3;

    // Config word layout
    localparam int CFG_W = 14;
    localparam int F_RATE = 0;
    localparam int F_PAR = 2;
    localparam int F_TRL = 4;
    localparam int F_PATH = 6;
    localparam int F_POLL = 7;
    localparam int F_KIND = 8;
    localparam int F_EXT = 9;
    localparam int F_C39C = 10;
    localparam int F_I25C = 11;
    localparam int F_SCHK = 12;
    localparam int F_SYM = 13;

    // Timing
    localparam int GOOD_MS = 200;
    localparam int GOOD_CYC = CLK_HZ / 1000 * GOOD_MS;
    localparam int WDT_TIMEOUT_MS = 1600;
    localparam int WDT_PERIOD_CYC = CLK_HZ / 1000 * (WDT_TIMEOUT_MS / 4);
    localparam logic [3:0] WDT_PULSE_CYC = 4'h8;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [3:0] FRAME_BITS = 4'hB;

    // Characters and sizes
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_TAB = 8'h09;
    localparam int FIFO_DEPTH = 8;
    localparam int HDR_MAX = 10;
    localparam logic [15:0] SIG_INIT = 16'hFFFF;
endpackage

// *** strap_config_serial_output.sv ***
// Purpose: Strap defaults, message framing and flow-controlled serial output
// Assumes: All inputs synchronous to CLK_SYS except straps and clear-to-send
// Notes: Label bytes pass through an 8-word FIFO before framing
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Label byte FIFO
module label_fifo #(
    parameter int W = 9,
    parameter int D = scan_out_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic full;

    // Extra pointer bit tells full from empty
    assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = (wp_r != rp_r);
    assign out_data = mem[rp_r[AW-1:0]];

    // Write side
    always_ff @(posedge clk) begin
        if (ce && in_valid && !full) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (ce) begin
            if (in_valid && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_ready && out_valid) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule // label_fifo

////////////////////////////////////////////////////////////////////////////////
module strap_config_serial_output #(
    parameter int GOOD_CYCLES = scan_out_pkg::GOOD_CYC,
    parameter int WDT_PERIOD = scan_out_pkg::WDT_PERIOD_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic RATE_SEL_A,
    input wire logic RATE_SEL_B,
    input wire logic PARITY_SEL_A,
    input wire logic PARITY_SEL_B,
    input wire logic TRAILER_SEL_A,
    input wire logic TRAILER_SEL_B,
    input wire logic OUTPUT_PATH_SELECT,
    input wire logic POLLED_MODE_SELECT,
    input wire logic SCANNER_KIND_SELECT,
    input wire logic EXTENDED_SYMBOLOGY_ENABLE,
    input wire logic CODE39_CHECKSUM_ENABLE,
    input wire logic I25_CHECKSUM_ENABLE,
    input wire logic SEND_CHECKSUM_CHAR,
    input wire logic SYMBOLOGY_SELECT,
    input wire logic STORE_VALID,
    input wire logic [13:0] STORE_CFG,
    input wire logic PROG_WR,
    input wire logic [13:0] PROG_CFG,
    input wire logic ID_EN,
    input wire logic [7:0] ID_CHAR,
    input wire logic [3:0] HDR_LEN,
    input wire logic [79:0] HDR_CHARS,
    input wire logic LABEL_VALID,
    input wire logic [7:0] LABEL_DATA,
    input wire logic LABEL_LAST,
    output logic LABEL_READY,
    input wire logic DECODE_DONE,
    input wire logic CHECK_BAD,
    input wire logic POLL_REQ,
    input wire logic COMPARE_EN,
    input wire logic BUTTON_N,
    input wire logic MATCH_CMD_WR,
    input wire logic MATCH_CMD_ON,
    input wire logic SCAN_DATA,
    input wire logic CTS_N,
    input wire logic KEYBOARD_PATH_CONTROL,
    output logic RTS_N,
    output logic TXD,
    output logic WEDGE_VALID,
    output logic [7:0] WEDGE_DATA,
    output logic GOOD_LED,
    output logic NO_READ,
    output logic SUPERVISOR_PULSE,
    output logic MATCH_OUTPUT,
    output logic BAR_DETECT,
    output logic [13:0] CFG_ACTIVE
);
    typedef enum logic [2:0] {S_IDLE, S_ID, S_HDR, S_DATA, S_TRL, S_TRL2} frame_e;

    logic [13:0] strap_raw;
    logic [13:0] strap_s1_r;
    logic [13:0] strap_s2_r;
    logic cts_s1_r;
    logic cts_s2_r;
    logic [1:0] settle_r;
    logic [13:0] cfg_r;
    frame_e st_r;
    frame_e st_nxt;
    logic [3:0] hidx_r;
    logic [7:0] ch;
    logic ch_v;
    logic go;
    logic start;
    logic wedge;
    logic poll_pend_r;
    logic f_valid;
    logic [8:0] f_data;
    logic [10:0] sh_r;
    logic [3:0] nbits_r;
    logic [16:0] bcnt_r;
    logic tx_busy;
    logic load;
    logic [31:0] gcnt_r;
    logic [31:0] wcnt_r;
    logic [3:0] wpulse_r;
    logic [15:0] sig_r;
    logic [15:0] sig_nxt;
    logic [15:0] last_sig_r;
    logic [15:0] cmp_sig_r;
    logic cmp_set_r;
    logic match_r;
    logic cmd_on_r;
    logic btn_r;
    logic good;

    // Baud divisor from rate code
    function automatic logic [16:0] div_of(input logic [1:0] rc);
        case (rc)
            scan_out_pkg::RATE_19200: div_of = scan_out_pkg::DIV_19200;
            scan_out_pkg::RATE_4800: div_of = scan_out_pkg::DIV_4800;
            scan_out_pkg::RATE_2400: div_of = scan_out_pkg::DIV_2400;
            default: div_of = scan_out_pkg::DIV_9600;
        endcase
    endfunction

    // Parity bit for one character
    function automatic logic par_of(input logic [1:0] pm, input logic [7:0] c);
        case (pm)
            scan_out_pkg::PAR_EVEN: par_of = ^c;
            scan_out_pkg::PAR_MARK: par_of = 1'b1;
            scan_out_pkg::PAR_ODD: par_of = ~^c;
            default: par_of = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Strap and clear-to-send synchronisers
    assign strap_raw = {SYMBOLOGY_SELECT, SEND_CHECKSUM_CHAR, I25_CHECKSUM_ENABLE,
        CODE39_CHECKSUM_ENABLE, EXTENDED_SYMBOLOGY_ENABLE, SCANNER_KIND_SELECT,
        POLLED_MODE_SELECT, OUTPUT_PATH_SELECT, TRAILER_SEL_A, TRAILER_SEL_B,
        PARITY_SEL_A, PARITY_SEL_B, RATE_SEL_A, RATE_SEL_B};

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
            cts_s1_r <= 1'b1;
            cts_s2_r <= 1'b1;
        end else if (CE) begin
            strap_s1_r <= strap_raw;
            strap_s2_r <= strap_s1_r;
            cts_s1_r <= CTS_N;
            cts_s2_r <= cts_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active configuration: stored, strap or programmed
    // strap codes land in rate, parity and trailer fields
    // straps unless stored copy is valid; programming overrides
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            settle_r <= '0;
            cfg_r <= '0;
        end else if (CE) begin
            if (settle_r != scan_out_pkg::STRAP_SETTLE) begin
                settle_r <= settle_r + 2'h1;
                if (settle_r == scan_out_pkg::STRAP_SETTLE - 2'h1) begin
                    cfg_r <= STORE_VALID ? STORE_CFG : strap_s2_r;
                end
            end else if (PROG_WR) begin
                cfg_r <= PROG_CFG;
            end
        end
    end
    assign CFG_ACTIVE = cfg_r;

    ////////////////////////////////////////////////////////////////////////////
    // Label FIFO with running signature for compare
    label_fifo #(.W(9), .D(scan_out_pkg::FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .in_valid(LABEL_VALID),
        .in_data({LABEL_LAST, LABEL_DATA}),
        .in_ready(LABEL_READY),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(go && st_r == S_DATA)
    );

    // Signature is a cheap stand-in for holding whole labels
    assign sig_nxt = {sig_r[14:0], sig_r[15]} ^ {8'h00, LABEL_DATA};

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sig_r <= scan_out_pkg::SIG_INIT;
            last_sig_r <= scan_out_pkg::SIG_INIT;
            cmp_sig_r <= scan_out_pkg::SIG_INIT;
            cmp_set_r <= 1'b0;
            match_r <= 1'b0;
            btn_r <= 1'b1;
        end else if (CE) begin
            btn_r <= BUTTON_N;
            if (LABEL_VALID && LABEL_READY) begin
                sig_r <= LABEL_LAST ? scan_out_pkg::SIG_INIT : sig_nxt;
                if (LABEL_LAST) begin
                    last_sig_r <= sig_nxt;
                    match_r <= cmp_set_r && (sig_nxt == cmp_sig_r);
                end
            end
            if (COMPARE_EN && btn_r && !BUTTON_N) begin
                cmp_sig_r <= last_sig_r;
                cmp_set_r <= 1'b1;
            end
        end
    end

    // match output: compare result or command level
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cmd_on_r <= 1'b0;
            MATCH_OUTPUT <= 1'b1;
        end else if (CE) begin
            if (MATCH_CMD_WR) begin
                cmd_on_r <= MATCH_CMD_ON;
            end
            MATCH_OUTPUT <= COMPARE_EN ? !match_r : cmd_on_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Message framer
    // path strap steers characters to one output only
    assign wedge = cfg_r[scan_out_pkg::F_PATH];
    // polled mode waits for a host request
    assign start = (st_r == S_IDLE) && f_valid
        && (!cfg_r[scan_out_pkg::F_POLL] || poll_pend_r);
    // a serial character starts only with clear-to-send low and line idle; a wedge character waits for keyboard path control
    assign go = ch_v && (wedge ? KEYBOARD_PATH_CONTROL : (!tx_busy && !cts_s2_r));
    assign load = go && !wedge;

    always_comb begin
        st_nxt = st_r;
        ch = 8'h00;
        ch_v = 1'b0;
        case (st_r)
            S_IDLE: begin
                if (start) begin
                    st_nxt = ID_EN ? S_ID : ((HDR_LEN != 4'h0) ? S_HDR : S_DATA);
                end
            end
            S_ID: begin
                ch = ID_CHAR;
                ch_v = 1'b1;
                if (go) begin
                    st_nxt = (HDR_LEN != 4'h0) ? S_HDR : S_DATA;
                end
            end
            S_HDR: begin
                ch = HDR_CHARS[hidx_r * 8 +: 8];
                ch_v = 1'b1;
                if (go && (hidx_r == HDR_LEN - 4'h1)) begin
                    st_nxt = S_DATA;
                end
            end
            S_DATA: begin
                ch = f_data[7:0];
                ch_v = f_valid;
                if (go && f_data[8]) begin
                    st_nxt = (cfg_r[5:4] == scan_out_pkg::TRL_NONE) ? S_IDLE : S_TRL;
                end
            end
            S_TRL: begin
                ch = (cfg_r[5:4] == scan_out_pkg::TRL_TAB) ? scan_out_pkg::CH_TAB
                    : scan_out_pkg::CH_CR;
                ch_v = 1'b1;
                if (go) begin
                    st_nxt = (cfg_r[5:4] == scan_out_pkg::TRL_CRLF) ? S_TRL2 : S_IDLE;
                end
            end
            S_TRL2: begin
                ch = scan_out_pkg::CH_LF;
                ch_v = 1'b1;
                if (go) begin
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    // Framer state and header index
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= S_IDLE;
            hidx_r <= '0;
        end else if (CE) begin
            st_r <= st_nxt;
            if (st_r != S_HDR) begin
                hidx_r <= '0;
            end else if (go) begin
                hidx_r <= hidx_r + 4'h1;
            end
        end
    end

    // Poll request held until a message starts; a new request wins
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            poll_pend_r <= 1'b0;
        end else if (CE) begin
            if (POLL_REQ) begin
                poll_pend_r <= 1'b1;
            end else if (start) begin
                poll_pend_r <= 1'b0;
            end
        end
    end

    // Wedge strobe with registered data
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            WEDGE_VALID <= 1'b0;
            WEDGE_DATA <= 8'h00;
        end else if (CE) begin
            WEDGE_VALID <= go && wedge;
            if (go && wedge) begin
                WEDGE_DATA <= ch;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial transmitter: start, 8 data LSB first, parity, one stop
    assign tx_busy = (nbits_r != 4'h0);
    assign TXD = sh_r[0];

    // a started character always runs to its stop bit
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sh_r <= '1;
            nbits_r <= '0;
            bcnt_r <= '0;
        end else if (CE) begin
            if (load) begin
                sh_r <= {1'b1, par_of(cfg_r[3:2], ch), ch, 1'b0};
                nbits_r <= scan_out_pkg::FRAME_BITS;
                bcnt_r <= div_of(cfg_r[1:0]) - 17'h1;
            end else if (tx_busy) begin
                if (bcnt_r == 17'h0) begin
                    sh_r <= {1'b1, sh_r[10:1]};
                    nbits_r <= nbits_r - 4'h1;
                    bcnt_r <= div_of(cfg_r[1:0]) - 17'h1;
                end else begin
                    bcnt_r <= bcnt_r - 17'h1;
                end
            end
        end
    end

    // request-to-send low from message start to last stop bit
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RTS_N <= 1'b1;
        end else if (CE) begin
            RTS_N <= !(!wedge && (start || st_r != S_IDLE || tx_busy));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode result, indicator and supervisor pulses
    // enabled check of the selected code turns a bad check into no-read
    assign good = DECODE_DONE && !(CHECK_BAD && (cfg_r[scan_out_pkg::F_SYM]
        ? cfg_r[scan_out_pkg::F_C39C] : cfg_r[scan_out_pkg::F_I25C]));

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            gcnt_r <= '0;
            GOOD_LED <= 1'b0;
            NO_READ <= 1'b0;
        end else if (CE) begin
            NO_READ <= DECODE_DONE && !good;
            if (good) begin
                gcnt_r <= 32'(GOOD_CYCLES - 1);
                GOOD_LED <= 1'b1;
            end else if (gcnt_r != 32'h0) begin
                gcnt_r <= gcnt_r - 32'h1;
            end else begin
                GOOD_LED <= 1'b0;
            end
        end
    end

    // supervisor pulse at a quarter of its timeout
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            wcnt_r <= '0;
            wpulse_r <= '0;
            SUPERVISOR_PULSE <= 1'b0;
        end else if (CE) begin
            SUPERVISOR_PULSE <= (wpulse_r != 4'h0);
            if (wcnt_r == 32'(WDT_PERIOD - 1)) begin
                wcnt_r <= '0;
                wpulse_r <= scan_out_pkg::WDT_PULSE_CYC;
            end else begin
                wcnt_r <= wcnt_r + 32'h1;
                if (wpulse_r != 4'h0) begin
                    wpulse_r <= wpulse_r - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            BAR_DETECT <= 1'b0;
        end else if (CE) begin
            BAR_DETECT <= cfg_r[scan_out_pkg::F_KIND] ? !SCAN_DATA : SCAN_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_char_start;
        CE && load;
    endsequence

    a_rts_hold: assert property (CE && tx_busy |=> !RTS_N)
        else $error("request-to-send released during a character");
    a_cts_gate: assert property (s_char_start |-> !cts_s2_r)
        else $error("character started without clear-to-send");
    a_start_bit: assert property (s_char_start |=> !TXD && tx_busy)
        else $error("character did not open with a start bit");
    a_rts_early: assert property (CE && start && !wedge |=> !RTS_N)
        else $error("request-to-send late for waiting data");
    a_wedge_quiet: assert property (wedge |-> !load && TXD)
        else $error("serial line active on wedge path");
    a_poll_wait: assert property (CE && start && cfg_r[7] |-> poll_pend_r)
        else $error("polled message started without request");
    a_good_len: assert property (CE && good |=> GOOD_LED [*8])
        else $error("indicator pulse too short");
    a_match_cmd: assert property (CE && !COMPARE_EN && !MATCH_CMD_WR
        |=> MATCH_OUTPUT == $past(cmd_on_r))
        else $error("match output ignores command level");
    a_strap_load: assert property (CE && settle_r == 2'h2 && !STORE_VALID
        |=> cfg_r == $past(strap_s2_r))
        else $error("strap defaults not loaded");
endmodule // strap_config_serial_output

// *** strap_config_serial_output_tb.sv ***
// Purpose: Self-checking bench for straps, framing and flow control
// Assumes: Short good-read and supervisor counts
// Notes: Serial runs at 19200, so only a frame's opening bits are watched
`timescale 1ns/1ps
module strap_config_serial_output_tb;
    localparam int GOODC = 20;
    logic clk, rst_n, ra, rb, pa, pb, tra, trb, path, poll, kind, ext, c39, i25, schk, sym;
    logic sv, pw, id_en, lv, ll, lr, dd, bad, mw, mon, scan, cts_n, kbd, rts_n, txd, wv;
    logic led, nr, sup, mo, bar, allow, preq, cen, btn_n;
    logic [13:0] scfg, pcfg, cfg;
    logic [7:0] idc, ld, wd, rxb;
    logic [3:0] hlen;
    logic [79:0] hch;
    int rxn;
    int num_errors = 0;
    int checked = 0;

    strap_config_serial_output #(.GOOD_CYCLES(GOODC), .WDT_PERIOD(50)) i_dut (
        .CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .RATE_SEL_A(ra), .RATE_SEL_B(rb),
        .PARITY_SEL_A(pa), .PARITY_SEL_B(pb), .TRAILER_SEL_A(tra), .TRAILER_SEL_B(trb),
        .OUTPUT_PATH_SELECT(path), .POLLED_MODE_SELECT(poll), .SCANNER_KIND_SELECT(kind),
        .EXTENDED_SYMBOLOGY_ENABLE(ext), .CODE39_CHECKSUM_ENABLE(c39),
        .I25_CHECKSUM_ENABLE(i25), .SEND_CHECKSUM_CHAR(schk), .SYMBOLOGY_SELECT(sym),
        .STORE_VALID(sv), .STORE_CFG(scfg), .PROG_WR(pw), .PROG_CFG(pcfg), .ID_EN(id_en),
        .ID_CHAR(idc), .HDR_LEN(hlen), .HDR_CHARS(hch), .LABEL_VALID(lv), .LABEL_DATA(ld),
        .LABEL_LAST(ll), .LABEL_READY(lr), .DECODE_DONE(dd), .CHECK_BAD(bad), .POLL_REQ(preq),
        .COMPARE_EN(cen), .BUTTON_N(btn_n), .MATCH_CMD_WR(mw), .MATCH_CMD_ON(mon),
        .SCAN_DATA(scan), .CTS_N(cts_n), .KEYBOARD_PATH_CONTROL(kbd), .RTS_N(rts_n),
        .TXD(txd), .WEDGE_VALID(wv), .WEDGE_DATA(wd), .GOOD_LED(led), .NO_READ(nr),
        .SUPERVISOR_PULSE(sup), .MATCH_OUTPUT(mo), .BAR_DETECT(bar), .CFG_ACTIVE(cfg));

    host_terminal #(.BIT_CYC(int'(scan_out_pkg::DIV_19200))) i_host (.clk(clk),
        .rts_n(rts_n), .txd(txd), .allow(allow), .cts_n(cts_n), .rx_byte(rxb), .rx_bits(rxn));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk1(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic chkw(input logic [13:0] got, input logic [13:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic hang();
        num_errors++;
        report_and_stop();
    endtask

    // Inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Straps stay still across reset so they pass the sync flops cleanly
    task automatic do_reset();
        rst_n = 1'b0;
        tick(5);
        rst_n = 1'b1;
        tick(5);
    endtask

    function automatic logic [13:0] straps();
        return {sym, schk, i25, c39, ext, kind, poll, path, tra, trb, pa, pb, ra, rb};
    endfunction

    // Valid stays up on return; the caller drops it
    task automatic push(input logic [7:0] d, input logic last);
        int w;
        w = 0;
        lv = 1'b1;
        ld = d;
        ll = last;
        while (lr !== 1'b1) begin
            tick(1);
            w++;
            if (w > 100) hang();
        end
        tick(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic strap_defaults();
        for (int i = 0; i < 4; i++) begin
            {sym, schk, i25, c39, ext, kind, poll, path} = 8'(8'h5A >> i);
            {tra, trb, pa, pb, ra, rb} = {2'(i ^ 1), 2'(3 - i), 2'(i)};
            scan = i[1];
            do_reset();
            chkw(cfg, straps(), "strap defaults");
            chk1(bar, scan ^ kind, "bar polarity");
        end
    endtask

    task automatic store_override();
        sv = 1'b1;
        scfg = 14'h2AAA;
        do_reset();
        chkw(cfg, 14'h2AAA, "stored config");
        // programmed word stands in for an escape sequence
        pcfg = 14'h1555;
        pw = 1'b1;
        tick(1);
        pw = 1'b0;
        tick(2);
        chkw(cfg, 14'h1555, "programmed config");
        sv = 1'b0;
        do_reset();
        chkw(cfg, straps(), "fallback to straps");
    endtask

    task automatic decode_check();
        int n;
        {poll, ext, c39, schk, sym, i25} = 6'h01;
        do_reset();
        n = 0;
        for (int i = 0; i < 70; i++) begin
            tick(1);
            n += int'(sup === 1'b1);
        end
        chkw(14'(n), 14'h0008, "supervisor pulse");
        dd = 1'b1;
        tick(1);
        dd = 1'b0;
        chk1(led, 1'b1, "led on");
        tick(GOODC - 1);
        chk1(led, 1'b1, "led held");
        tick(1);
        chk1(led, 1'b0, "led off");
        dd = 1'b1;
        bad = 1'b1;
        tick(1);
        dd = 1'b0;
        chk1(nr, 1'b1, "no-read");
        chk1(led, 1'b0, "no led on bad check");
        // Code 39 with its own check, then with only the other code's check
        for (int i = 0; i < 2; i++) begin
            pcfg = i[0] ? 14'h2800 : 14'h2400;
            pw = 1'b1;
            tick(1);
            {pw, dd} = 2'b01;
            tick(1);
            dd = 1'b0;
            chk1(nr, !i[0], "code-39 check");
            chk1(led, i[0], "check follows symbology");
        end
        for (int i = 0; i < 2; i++) begin
            mon = i[0];
            mw = 1'b1;
            tick(1);
            mw = 1'b0;
            tick(2);
            chk1(mo, i[0], "match command");
        end
        // Button captures label A; A again matches, B does not
        cen = 1'b1;
        push(8'h41, 1'b1);
        {lv, btn_n} = 2'b00;
        tick(1);
        btn_n = 1'b1;
        for (int i = 0; i < 2; i++) begin
            push(8'(8'h41 + i), 1'b1);
            lv = 1'b0;
            tick(1);
            chk1(mo, i[0], "compare result");
        end
        cen = 1'b0;
    endtask

    // Wedge stalled: ID waits, FIFO fills to 8 and refuses, then drains
    task automatic wedge_frame();
        logic [7:0] exp [13] = '{8'h49, 8'h48, 8'h44, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
            8'h35, 8'h36, 8'h37, scan_out_pkg::CH_CR, scan_out_pkg::CH_LF};
        int w;
        {path, tra, trb} = 3'b101;
        do_reset();
        {id_en, idc, hlen, hch} = {1'b1, 8'h49, 4'h2, 80'h4448};
        for (int i = 0; i < 8; i++) push(8'(8'h30 + i), i == 7);
        chk1(lr, 1'b0, "buffer full");
        lv = 1'b0;
        kbd = 1'b1;
        for (int n = 0; n < 13; n++) begin
            w = 0;
            do begin
                tick(1);
                w++;
                if (w > 500) hang();
            end while (wv !== 1'b1);
            chkw(14'(wd), 14'(exp[n]), "wedge char");
            chk1(txd & rts_n, 1'b1, "serial quiet in wedge mode");
        end
    endtask

    task automatic serial_frame();
        int w;
        {poll, path, ra, rb, tra, trb} = 6'b101000;
        do_reset();
        {idc, hlen} = {8'hA5, 4'h0};
        push(8'h41, 1'b1);
        lv = 1'b0;
        tick(200);
        chk1(rts_n, 1'b1, "polled data waits for request");
        preq = 1'b1;
        tick(1);
        preq = 1'b0;
        tick(200);
        chk1(rts_n, 1'b0, "request raised");
        chk1(txd, 1'b1, "held by clear-to-send");
        allow = 1'b1;
        w = 0;
        while (rxn < 3) begin
            tick(100);
            w++;
            if (w > 600) hang();
        end
        chkw(14'(rxb[2:0]), 14'h0005, "identifier bits");
        chk1(rts_n, 1'b0, "request held");
    endtask

    initial begin
        {rst_n, ra, rb, pa, pb, tra, trb, path, poll, kind, ext, c39, i25, schk, sym} = '0;
        {sv, pw, id_en, lv, ll, dd, bad, mw, mon, scan, kbd, allow, preq, cen} = '0;
        btn_n = 1'b1;
        {scfg, pcfg, idc, ld, hlen, hch} = '0;
        strap_defaults();
        store_override();
        decode_check();
        wedge_frame();
        serial_frame();
        report_and_stop();
    end
endmodule // strap_config_serial_output_tb
